// ---- lcot_defines.svh ----
// Constants for the ladder coil, one-shot and timer unit.
// Assumes inclusion by bare name from the package and the unit itself.
`ifndef LCOT_DEFINES_SVH
`define LCOT_DEFINES_SVH

// Sizes of the timer bank, the bit space and the relay outputs.
`define LCOT_N_TIMERS 64
`define LCOT_N_BITS 64
`define LCOT_N_RELAY 16

// Timebase: 10 ms tick derived from a 40 ns clock.
`define LCOT_TICK_NS 10000000
`define LCOT_CLK_NS 40

// Element numbers of one timer in the host window.
`define LCOT_EL_ENABLED 3'h0
`define LCOT_EL_RUNNING 3'h1
`define LCOT_EL_DONE 3'h2
`define LCOT_EL_PRESET 3'h3
`define LCOT_EL_VALUE 3'h4

// Host register offsets outside the timer window.
`define LCOT_REG_STATUS 10'h200
`define LCOT_REG_RELAY 10'h201
`define LCOT_STAT_ERR 0

// Sign bit of preset and value; a set sign is a runtime error.
`define LCOT_SIGN_BIT 15

`endif

// ---- lcot_pkg.sv ----
// Types shared by the ladder coil, one-shot and timer unit.
// Assumes lcot_defines.svh is on the include path.
`default_nettype none
`include "lcot_defines.svh"

package lcot_pkg;

	// Ladder elements the unit executes, one per cycle.
	typedef enum logic [3:0] {
		OP_RUNG_START,
		OP_BRANCH,
		OP_EXAM_CLOSED,
		OP_EXAM_OPEN,
		OP_ENERGIZE,
		OP_LATCH,
		OP_UNLATCH,
		OP_ONE_SHOT,
		OP_ON_DELAY,
		OP_OFF_DELAY,
		OP_RETENTIVE,
		OP_RESET_TMR
	} lcot_op_t;

	// Address spaces an element may point into.
	typedef enum logic [1:0] {
		SP_INPUT,
		SP_BIT,
		SP_TIMER
	} lcot_space_t;

	// One ladder element as issued by the scan sequencer.
	typedef struct packed {
		lcot_op_t op;
		lcot_space_t space;
		logic [5:0] index;
		logic [2:0] sel;
	} lcot_elem_t;

	// One timer: three flags, preset and accumulated value.
	typedef struct packed {
		logic en;
		logic run;
		logic done;
		logic [15:0] preset;
		logic [15:0] value;
	} lcot_tmr_t;

	// Whole state of the unit.
	typedef struct packed {
		lcot_tmr_t [`LCOT_N_TIMERS-1:0] tmr;
		logic [`LCOT_N_TIMERS-1:0] tick_pend;
		logic [`LCOT_N_BITS-1:0] bits;
		logic [`LCOT_N_BITS-1:0] ote_mask;
		logic [`LCOT_N_BITS-1:0] sync1;
		logic [`LCOT_N_BITS-1:0] sync2;
		logic [31:0] div;
		logic tick;
		logic acc;
		logic orv;
		logic ack;
		logic result;
		logic err;
		logic [15:0] rdata;
	} lcot_state_t;

endpackage
`default_nettype wire

// ---- lcot_unit.sv ----
// Ladder coil, one-shot and timer unit: executes one ladder element per cycle.
// Assumes a scan sequencer on the same clock issuing elements in program order,
// a host on the same clock, and contact pins that are asynchronous.
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "lcot_defines.svh"

module lcot_unit #(
	parameter int unsigned TICK_CYCLES = `LCOT_TICK_NS / `LCOT_CLK_NS
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [`LCOT_N_BITS-1:0] contact_level_n,
	input wire logic prog_restart,
	input wire logic el_valid,
	input wire lcot_pkg::lcot_elem_t el,
	output logic el_ack,
	output logic el_result,
	output logic [`LCOT_N_RELAY-1:0] relay_out,
	output logic runtime_err,
	input wire logic [9:0] host_addr,
	input wire logic [15:0] host_wdata,
	input wire logic host_wr,
	input wire logic host_rd,
	output logic [15:0] host_rdata
);
	import lcot_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Helpers.

	// Value of the bit an examine element looks at.
	function automatic logic src_bit(input lcot_state_t s, input lcot_elem_t e);
		logic v;
		v = 1'b0;
		unique case (e.space)
			SP_INPUT: v = ~s.sync2[e.index];
			SP_BIT: v = s.bits[e.index];
			SP_TIMER: begin
				unique case (e.sel)
					`LCOT_EL_ENABLED: v = s.tmr[e.index].en;
					`LCOT_EL_RUNNING: v = s.tmr[e.index].run;
					`LCOT_EL_DONE: v = s.tmr[e.index].done;
					default: v = 1'b0;
				endcase
			end
			default: v = 1'b0;
		endcase
		return v;
	endfunction

	// A set sign bit in preset or value is illegal for a timer.
	function automatic logic tmr_neg(input lcot_tmr_t t);
		return t.preset[`LCOT_SIGN_BIT] | t.value[`LCOT_SIGN_BIT];
	endfunction

	// One execution of a timer element of the given mode.
	function automatic lcot_tmr_t tmr_step(input lcot_tmr_t t, input lcot_op_t op,
			input logic rung, input logic tk);
		lcot_tmr_t r;
		logic timing;
		logic [15:0] vn;
		r = t;
		vn = t.value;
		timing = (op == OP_OFF_DELAY) ? !rung : rung;
		if (timing) begin
			if (tk && (t.value < t.preset)) begin
				vn = 16'(t.value + 16'h0001);
			end
		end else if (op != OP_RETENTIVE) begin
			vn = 16'h0000;
		end
		r.value = vn;
		r.en = rung;
		r.run = timing && (vn < t.preset);
		if (op == OP_OFF_DELAY) begin
			r.done = rung || (vn < t.preset);
		end else begin
			r.done = rung && (vn >= t.preset);
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State and next state.

	lcot_state_t s_q;
	lcot_state_t s_d;
	lcot_tmr_t cur;
	logic rung;
	logic tick;
	logic err_set;
	logic exam_v;
	logic [15:0] rd_val;

	// The bank holds every timer; an element names exactly one by index.
	assign cur = s_q.tmr[el.index];
	// A rung is true when a finished branch or the open branch is true.
	assign rung = s_q.orv | s_q.acc;
	assign exam_v = src_bit(s_q, el);

	// Element execution, timebase, host access and restart in one pass.
	// Host writes come after the element so a forced value always lands.
	always_comb begin
		s_d = s_q;
		err_set = 1'b0;
		rd_val = 16'h0000;
		s_d.sync1 = contact_level_n;
		s_d.sync2 = s_q.sync1;
		tick = (s_q.div == 32'(TICK_CYCLES - 1));
		s_d.div = tick ? 32'h0000_0000 : 32'(s_q.div + 32'h0000_0001);
		s_d.tick = tick;
		s_d.ack = el_valid;
		if (el_valid) begin
			s_d.result = rung;
			unique case (el.op)
				OP_RUNG_START: begin
					s_d.acc = 1'b1;
					s_d.orv = 1'b0;
				end
				OP_BRANCH: begin
					s_d.orv = rung;
					s_d.acc = 1'b1;
				end
				OP_EXAM_CLOSED: begin
					s_d.acc = s_q.acc & exam_v;
					s_d.result = s_q.acc & exam_v;
				end
				OP_EXAM_OPEN: begin
					s_d.acc = s_q.acc & ~exam_v;
					s_d.result = s_q.acc & ~exam_v;
				end
				OP_ENERGIZE: begin
					s_d.bits[el.index] = rung;
					s_d.ote_mask[el.index] = 1'b1;
				end
				OP_LATCH: begin
					if (rung) begin
						s_d.bits[el.index] = 1'b1;
					end
				end
				OP_UNLATCH: begin
					if (rung) begin
						s_d.bits[el.index] = 1'b0;
					end
				end
				OP_ONE_SHOT: begin
					// The storage bit must be unique to this element.
					s_d.bits[el.index] = s_q.acc;
					s_d.acc = s_q.acc & ~s_q.bits[el.index];
					s_d.result = s_q.acc & ~s_q.bits[el.index];
				end
				OP_ON_DELAY, OP_OFF_DELAY, OP_RETENTIVE: begin
					if (tmr_neg(cur)) begin
						err_set = 1'b1;
					end else begin
						s_d.tmr[el.index] = tmr_step(cur, el.op, rung,
							s_q.tick_pend[el.index]);
						s_d.tick_pend[el.index] = 1'b0;
					end
				end
				OP_RESET_TMR: begin
					if (rung) begin
						s_d.tmr[el.index].en = 1'b0;
						s_d.tmr[el.index].run = 1'b0;
						s_d.tmr[el.index].done = 1'b0;
						s_d.tmr[el.index].value = 16'h0000;
					end
				end
				default: begin
					s_d.result = 1'b0;
				end
			endcase
		end
		// A tick arriving with a consumption still counts for the next scan.
		if (tick) begin
			s_d.tick_pend = '1;
		end
		// Host forces a timer element or clears the sticky error.
		if (host_wr) begin
			if (!host_addr[9]) begin
				unique case (host_addr[2:0])
					`LCOT_EL_ENABLED: s_d.tmr[host_addr[8:3]].en = host_wdata[0];
					`LCOT_EL_RUNNING: s_d.tmr[host_addr[8:3]].run = host_wdata[0];
					`LCOT_EL_DONE: s_d.tmr[host_addr[8:3]].done = host_wdata[0];
					`LCOT_EL_PRESET: s_d.tmr[host_addr[8:3]].preset = host_wdata;
					`LCOT_EL_VALUE: s_d.tmr[host_addr[8:3]].value = host_wdata;
					default: begin
					end
				endcase
			end
		end
		// The error flag is write-one-to-clear; a new error wins.
		s_d.err = (s_q.err & ~(host_wr && (host_addr == `LCOT_REG_STATUS)
			&& host_wdata[`LCOT_STAT_ERR])) | err_set;
		// Read window: five elements per timer, then status and relays.
		if (!host_addr[9]) begin
			unique case (host_addr[2:0])
				`LCOT_EL_ENABLED: rd_val = {15'h0000, s_q.tmr[host_addr[8:3]].en};
				`LCOT_EL_RUNNING: rd_val = {15'h0000, s_q.tmr[host_addr[8:3]].run};
				`LCOT_EL_DONE: rd_val = {15'h0000, s_q.tmr[host_addr[8:3]].done};
				`LCOT_EL_PRESET: rd_val = s_q.tmr[host_addr[8:3]].preset;
				`LCOT_EL_VALUE: rd_val = s_q.tmr[host_addr[8:3]].value;
				default: rd_val = 16'h0000;
			endcase
		end else if (host_addr == `LCOT_REG_STATUS) begin
			rd_val = {15'h0000, s_q.err};
		end else if (host_addr == `LCOT_REG_RELAY) begin
			rd_val = s_q.bits[`LCOT_N_RELAY-1:0];
		end
		s_d.rdata = host_rd ? rd_val : 16'h0000;
		// Restart drops every bit that an energize coil drove before this cycle.
		if (prog_restart) begin
			s_d.bits = s_d.bits & ~s_q.ote_mask;
		end
	end

	// Single register stage for the whole unit.
	always_ff @(posedge clk) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign el_ack = s_q.ack;
	assign el_result = s_q.result;
	assign relay_out = s_q.bits[`LCOT_N_RELAY-1:0];
	assign runtime_err = s_q.err;
	assign host_rdata = s_q.rdata;

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	// Cycles since the last tick; zero until the first tick is seen.
	logic [31:0] gap_q;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			gap_q <= 32'h0000_0000;
		end else if (s_q.tick) begin
			gap_q <= 32'h0000_0001;
		end else if (gap_q != 32'h0000_0000) begin
			gap_q <= 32'(gap_q + 32'h0000_0001);
		end
	end

	logic quiet;
	assign quiet = !host_wr && !prog_restart;

	// A one-shot sees a rise, a rung that stayed true, or a false rung.
	// Any scan but the rising one must leave the element false.
	sequence osr_fire;
		el_valid && el.op == OP_ONE_SHOT && s_q.acc && !s_q.bits[el.index];
	endsequence
	sequence osr_again;
		el_valid && el.op == OP_ONE_SHOT && s_q.bits[el.index];
	endsequence
	sequence osr_low;
		el_valid && el.op == OP_ONE_SHOT && !s_q.acc;
	endsequence

	exam_open_a: assert property (el_valid && el.op == OP_EXAM_OPEN && s_q.acc
		|=> el_result == !$past(exam_v))
		else $error("examine-open result wrong");
	energize_a: assert property (el_valid && el.op == OP_ENERGIZE && el.space == SP_BIT
		&& quiet |=> s_q.bits[$past(el.index)] == $past(rung))
		else $error("energize coil does not follow rung");
	restart_a: assert property (prog_restart && !el_valid
		|=> (s_q.bits & s_q.ote_mask) == '0)
		else $error("restart left an energize coil on");
	latch_a: assert property (el_valid && el.op == OP_LATCH && rung && quiet
		|=> s_q.bits[$past(el.index)])
		else $error("latch did not set its bit");
	unlatch_a: assert property (el_valid && el.op == OP_UNLATCH && rung
		|=> !s_q.bits[$past(el.index)])
		else $error("unlatch did not clear its bit");
	one_shot_a: assert property (osr_fire |=> el_result)
		else $error("one-shot false on a rising rung");
	one_shot_hold_a: assert property ((osr_again or osr_low) |=> !el_result)
		else $error("one-shot true without a new rise");
	one_shot_store_a: assert property (el_valid && el.op == OP_ONE_SHOT && quiet
		|=> s_q.bits[$past(el.index)] == $past(s_q.acc))
		else $error("one-shot storage bit not updated");
	elem_ack_a: assert property (el_valid |=> el_ack)
		else $error("element not acknowledged");
	err_sticky_a: assert property (runtime_err
		&& !(host_wr && host_addr == `LCOT_REG_STATUS && host_wdata[`LCOT_STAT_ERR])
		|=> runtime_err)
		else $error("runtime error dropped without a clear");
	tick_gap_a: assert property (s_q.tick && gap_q != 32'h0000_0000
		|-> gap_q == TICK_CYCLES)
		else $error("timebase tick spacing wrong");
	on_delay_off_a: assert property (el_valid && el.op == OP_ON_DELAY && !rung
		&& !tmr_neg(cur) && !host_wr
		|=> s_q.tmr[$past(el.index)].value == 16'h0000 && !s_q.tmr[$past(el.index)].done)
		else $error("on-delay not cleared on false rung");
	on_delay_done_a: assert property (el_valid && el.op == OP_ON_DELAY && rung
		&& !tmr_neg(cur) && cur.value >= cur.preset && !host_wr
		|=> s_q.tmr[$past(el.index)].done && !s_q.tmr[$past(el.index)].run)
		else $error("on-delay done or running wrong at preset");
	off_delay_a: assert property (el_valid && el.op == OP_OFF_DELAY && rung
		&& !tmr_neg(cur) && !host_wr
		|=> s_q.tmr[$past(el.index)].done && s_q.tmr[$past(el.index)].value == 16'h0000)
		else $error("off-delay not restored on true rung");
	retentive_a: assert property (el_valid && el.op == OP_RETENTIVE && !rung
		&& !tmr_neg(cur) && !host_wr
		|=> s_q.tmr[$past(el.index)].value == $past(cur.value))
		else $error("retentive timer lost its value");
	neg_err_a: assert property (el_valid && el.op inside {OP_ON_DELAY, OP_OFF_DELAY,
		OP_RETENTIVE} && tmr_neg(cur) |=> runtime_err)
		else $error("negative timer did not raise error");
	host_read_a: assert property (host_rd && !host_addr[9] && host_addr[2:0] == `LCOT_EL_VALUE
		|=> host_rdata == $past(s_q.tmr[host_addr[8:3]].value))
		else $error("host read of timer value wrong");

endmodule
`default_nettype wire

// ---- lcot_contacts.sv ----
// Field side model: the bank of contacts wired to the contact pins.
// Assumes the bench sets which contacts are closed, one bit per pin.
`timescale 1ns/100ps
`default_nettype none
`include "lcot_defines.svh"

module lcot_contacts (
	input wire logic [`LCOT_N_BITS-1:0] closed,
	output logic [`LCOT_N_BITS-1:0] contact_level_n
);
	// A closed contact pulls its pin to 0 V; an open one is pulled up to the supply.
	assign contact_level_n = ~closed;
endmodule
`default_nettype wire

// ---- tb_lcot_unit.sv ----
// Self-checking bench for the ladder coil, one-shot and timer unit.
// Assumes the package, the unit and the contact model are compiled before it.
`timescale 1ns/100ps
`default_nettype none
`include "lcot_defines.svh"

module tb_lcot_unit;
	import lcot_pkg::*;
	typedef struct packed {lcot_op_t op; logic [5:0] pin; logic closed; logic exp;} lcot_row_t;
	logic clk, resetn, prog_restart, el_valid, el_ack, el_result, runtime_err;
	logic host_wr, host_rd, r;
	lcot_elem_t el;
	logic [63:0] closed, contact_level_n;
	logic [15:0] relay_out, host_rdata, host_wdata, rd;
	logic [9:0] host_addr;
	int failures, tests_run;
	lcot_row_t rows [4];
	logic [3:0] osr_exp;

	// A short tick keeps timer scenarios to a few hundred cycles.
	lcot_unit #(.TICK_CYCLES(8)) lcot_unit_i (.clk(clk), .resetn(resetn),
		.contact_level_n(contact_level_n), .prog_restart(prog_restart),
		.el_valid(el_valid), .el(el), .el_ack(el_ack), .el_result(el_result),
		.relay_out(relay_out), .runtime_err(runtime_err), .host_addr(host_addr),
		.host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd),
		.host_rdata(host_rdata));
	lcot_contacts lcot_contacts_i (.closed(closed), .contact_level_n(contact_level_n));

	// Clock at 25 MHz.
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Compare and bus tasks.
	task chk1(input string n, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	task chk16(input string n, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	function automatic logic [9:0] taddr(input logic [5:0] t, input logic [2:0] e);
		return {1'b0, t, e};
	endfunction

	// Host write: one strobe cycle; the next access waits one edge so strobes never merge.
	task hwr(input logic [9:0] a, input logic [15:0] d);
		@(posedge clk);
		host_wr <= 1'b1;
		host_addr <= a;
		host_wdata <= d;
		@(posedge clk);
		host_wr <= 1'b0;
	endtask

	task hrd(input logic [9:0] a, output logic [15:0] d);
		@(posedge clk);
		host_rd <= 1'b1;
		host_addr <= a;
		@(posedge clk);
		host_rd <= 1'b0;
		#1 d = host_rdata;
	endtask

	// One element; its ack stands only in the cycle after it is taken, its answer until the next element.
	task el_go(input lcot_op_t o, input lcot_space_t s, input logic [5:0] i,
		input logic [2:0] l, output logic res);
		@(posedge clk);
		el_valid <= 1'b1;
		el <= lcot_elem_t'{o, s, i, l};
		@(posedge clk);
		el_valid <= 1'b0;
		#1 chk1("ack", 1'b1, el_ack);
		res = el_result;
	endtask

	// Rung controlled by bit 60, which nothing ever sets: open test true, closed test false.
	task rung(input lcot_op_t ex, input lcot_op_t c, input lcot_space_t cs,
		input logic [5:0] ci, output logic res);
		el_go(OP_RUNG_START, SP_BIT, 6'h00, 3'h0, res);
		el_go(ex, SP_BIT, 6'h3C, 3'h0, res);
		el_go(c, cs, ci, 3'h0, res);
	endtask

	// Scans spaced wider than a tick, so every execution has a tick pending.
	task tscan(input lcot_op_t ex, input lcot_op_t c, input logic [5:0] t, input int n);
		logic x;
		repeat (n) begin
			rung(ex, c, SP_TIMER, t, x);
			repeat (10) @(posedge clk);
		end
	endtask

	task tchk(input logic [5:0] t, input logic en, input logic run, input logic dn,
		input logic [15:0] v, input logic cv);
		logic [15:0] d;
		hrd(taddr(t, `LCOT_EL_ENABLED), d);
		chk1("enabled", en, d[0]);
		hrd(taddr(t, `LCOT_EL_RUNNING), d);
		chk1("running", run, d[0]);
		hrd(taddr(t, `LCOT_EL_DONE), d);
		chk1("done", dn, d[0]);
		hrd(taddr(t, `LCOT_EL_VALUE), d);
		if (cv) chk16("value", v, d);
	endtask

	task conclude;
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog sized well above the fewer than a thousand cycles the tests need.
	initial begin
		#(40 * 30000);
		failures++;
		conclude;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		resetn = 1'b0;
		prog_restart = 1'b0;
		el_valid = 1'b0;
		el = '0;
		host_wr = 1'b0;
		host_rd = 1'b0;
		host_addr = '0;
		host_wdata = '0;
		closed = '0;
		failures = 0;
		tests_run = 0;
		osr_exp = 4'h9;
		rows = '{'{OP_EXAM_OPEN, 6'h03, 1'b0, 1'b1}, '{OP_EXAM_OPEN, 6'h3F, 1'b1, 1'b0},
			'{OP_EXAM_CLOSED, 6'h03, 1'b0, 1'b0}, '{OP_EXAM_CLOSED, 6'h3F, 1'b1, 1'b1}};
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		#1 chk16("relay after reset", 16'h0000, relay_out);
		chk1("error after reset", 1'b0, runtime_err);
		$display("test reset done");
		// Contact rows: each drives relay k from one examine on a pin.
		foreach (rows[k]) begin
			@(posedge clk);
			closed <= 64'(rows[k].closed) << rows[k].pin;
			repeat (4) @(posedge clk);
			el_go(OP_RUNG_START, SP_INPUT, 6'h00, 3'h0, r);
			el_go(rows[k].op, SP_INPUT, rows[k].pin, 3'h0, r);
			chk1("examine", rows[k].exp, r);
			el_go(OP_ENERGIZE, SP_BIT, 6'(k), 3'h0, r);
			chk1("energized relay", rows[k].exp, relay_out[k]);
		end
		$display("test contact rows done");
		rung(OP_EXAM_OPEN, OP_LATCH, SP_BIT, 6'h04, r);
		chk1("latched", 1'b1, relay_out[4]);
		rung(OP_EXAM_CLOSED, OP_LATCH, SP_BIT, 6'h04, r);
		chk1("latch held", 1'b1, relay_out[4]);
		@(posedge clk);
		prog_restart <= 1'b1;
		@(posedge clk);
		prog_restart <= 1'b0;
		#1 chk16("relays after restart", 16'h0010, relay_out);
		rung(OP_EXAM_OPEN, OP_UNLATCH, SP_BIT, 6'h04, r);
		chk1("unlatched", 1'b0, relay_out[4]);
		rung(OP_EXAM_CLOSED, OP_ENERGIZE, SP_BIT, 6'h05, r);
		chk1("unlatch holds", 1'b0, relay_out[4]);
		$display("test coils done");
		// Parallel path: false branch then true branch; a later rung sees the new bit.
		el_go(OP_RUNG_START, SP_BIT, 6'h00, 3'h0, r);
		el_go(OP_EXAM_CLOSED, SP_BIT, 6'h3C, 3'h0, r);
		el_go(OP_BRANCH, SP_BIT, 6'h00, 3'h0, r);
		el_go(OP_EXAM_OPEN, SP_BIT, 6'h3C, 3'h0, r);
		el_go(OP_ENERGIZE, SP_BIT, 6'h09, 3'h0, r);
		chk1("branch relay", 1'b1, relay_out[9]);
		el_go(OP_RUNG_START, SP_BIT, 6'h00, 3'h0, r);
		el_go(OP_EXAM_CLOSED, SP_BIT, 6'h09, 3'h0, r);
		chk1("same scan bit", 1'b1, r);
		// One-shot: true, true, false, true gives pulses on the first and last scans.
		// The one-shot always sits on a plain series rung, never behind a branch.
		for (int k = 0; k < 4; k++) begin
			rung(k == 2 ? OP_EXAM_CLOSED : OP_EXAM_OPEN, OP_ONE_SHOT, SP_BIT, 6'h28, r);
			el_go(OP_ENERGIZE, SP_BIT, 6'h08, 3'h0, r);
			chk1("one shot", osr_exp[k], relay_out[8]);
		end
		$display("test branch and one shot done");
		hwr(taddr(6'h02, `LCOT_EL_PRESET), 16'h00C8);
		tscan(OP_EXAM_OPEN, OP_ON_DELAY, 6'h02, 2);
		tchk(6'h02, 1'b1, 1'b1, 1'b0, 16'h0000, 1'b0);
		hwr(taddr(6'h02, `LCOT_EL_PRESET), 16'h0003);
		tscan(OP_EXAM_OPEN, OP_ON_DELAY, 6'h02, 10);
		tchk(6'h02, 1'b1, 1'b0, 1'b1, 16'h0003, 1'b1);
		tscan(OP_EXAM_CLOSED, OP_ON_DELAY, 6'h02, 1);
		tchk(6'h02, 1'b0, 1'b0, 1'b0, 16'h0000, 1'b1);
		hwr(taddr(6'h05, `LCOT_EL_PRESET), 16'h0002);
		tscan(OP_EXAM_OPEN, OP_OFF_DELAY, 6'h05, 1);
		tchk(6'h05, 1'b1, 1'b0, 1'b1, 16'h0000, 1'b1);
		tscan(OP_EXAM_CLOSED, OP_OFF_DELAY, 6'h05, 1);
		tchk(6'h05, 1'b0, 1'b1, 1'b1, 16'h0000, 1'b0);
		tscan(OP_EXAM_CLOSED, OP_OFF_DELAY, 6'h05, 10);
		tchk(6'h05, 1'b0, 1'b0, 1'b0, 16'h0002, 1'b1);
		tscan(OP_EXAM_OPEN, OP_OFF_DELAY, 6'h05, 1);
		tchk(6'h05, 1'b1, 1'b0, 1'b1, 16'h0000, 1'b1);
		// Timer flags used as contacts: running is off and done is on here.
		el_go(OP_RUNG_START, SP_BIT, 6'h00, 3'h0, r);
		el_go(OP_EXAM_OPEN, SP_TIMER, 6'h05, `LCOT_EL_RUNNING, r);
		chk1("running contact", 1'b1, r);
		el_go(OP_EXAM_CLOSED, SP_TIMER, 6'h05, `LCOT_EL_DONE, r);
		chk1("done contact", 1'b1, r);
		$display("test on and off delay done");
		hwr(taddr(6'h3F, `LCOT_EL_PRESET), 16'h0003);
		hwr(taddr(6'h3F, `LCOT_EL_VALUE), 16'h0064);
		tscan(OP_EXAM_CLOSED, OP_RETENTIVE, 6'h3F, 3);
		tchk(6'h3F, 1'b0, 1'b0, 1'b0, 16'h0064, 1'b1);
		tscan(OP_EXAM_OPEN, OP_RETENTIVE, 6'h3F, 1);
		tchk(6'h3F, 1'b1, 1'b0, 1'b1, 16'h0000, 1'b0);
		// The reset element only ever meets the retentive timer, never an off-delay one.
		tscan(OP_EXAM_OPEN, OP_RESET_TMR, 6'h3F, 1);
		tchk(6'h3F, 1'b0, 1'b0, 1'b0, 16'h0000, 1'b1);
		$display("test retentive done");
		hwr(taddr(6'h07, `LCOT_EL_PRESET), 16'h8000);
		tscan(OP_EXAM_OPEN, OP_ON_DELAY, 6'h07, 3);
		#1 chk1("runtime error", 1'b1, runtime_err);
		hrd(taddr(6'h07, `LCOT_EL_VALUE), rd);
		chk16("stalled value", 16'h0000, rd);
		hrd(`LCOT_REG_STATUS, rd);
		chk16("error status", 16'h0001, rd);
		hwr(`LCOT_REG_STATUS, 16'h0001);
		#1 chk1("error cleared", 1'b0, runtime_err);
		hwr(taddr(6'h00, `LCOT_EL_PRESET), 16'h7FFF);
		hrd(taddr(6'h00, `LCOT_EL_PRESET), rd);
		chk16("max preset", 16'h7FFF, rd);
		hrd(taddr(6'h3F, `LCOT_EL_PRESET), rd);
		chk16("other timer preset", 16'h0003, rd);
		hrd(taddr(6'h03, 3'h5), rd);
		chk16("element five", 16'h0000, rd);
		hwr(taddr(6'h03, `LCOT_EL_DONE), 16'h0001);
		hrd(taddr(6'h03, `LCOT_EL_DONE), rd);
		chk16("forced done", 16'h0001, rd);
		hrd(10'h3FF, rd);
		chk16("unmapped", 16'h0000, rd);
		$display("test host and errors done");
		// Reset in mid-run while relays 8 and 9 are on and timer 0 holds a forced preset.
		hrd(`LCOT_REG_RELAY, rd);
		chk16("relays before mid reset", 16'h0300, rd);
		@(posedge clk);
		resetn <= 1'b0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		#1 chk16("relays after mid reset", 16'h0000, relay_out);
		hrd(taddr(6'h00, `LCOT_EL_PRESET), rd);
		chk16("preset after mid reset", 16'h0000, rd);
		$display("test mid-run reset done");
		conclude;
	end
endmodule
`default_nettype wire
